//--- design/rng_regs.svh
// constants for the hybrid random number block
`ifndef RNG_REGS_SVH
`define RNG_REGS_SVH
`define RNG_WORD_W 32
`define RNG_SEED_W 128
`define RNG_FIFO_DEPTH 8
`define RNG_WIN_LEN 128
`define RNG_ONES_LO 40
`define RNG_ONES_HI 88
`define RNG_RUN_LIMIT 32
`define RNG_UPD_K 128'h243F_6A88_85A3_08D3_1319_8A2E_0370_7344
`define RNG_OUT_K 128'hA409_3822_299F_31D0_082E_FA98_EC4E_6C89
`define RNG_CTR_ONE 32'h0000_0001
`endif

//--- design/rng_pkg.sv
// types shared by the random number block
package rng_pkg;
    typedef enum logic [1:0] {
        ST_WAIT = 2'b00,
        ST_GEN = 2'b01,
        ST_HALT = 2'b10
    } gen_state_t;
endpackage

//--- design/stream_if.sv
// valid/ready word stream between the generator and its buffer
`timescale 1ns/1ps
interface stream_if #(parameter int WIDTH = 32);
    logic [WIDTH-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

//--- design/word_fifo.sv
// word buffer with registered read data
`timescale 1ns/1ps
`include "rng_regs.svh"
module word_fifo #(
    parameter int WIDTH = `RNG_WORD_W,
    parameter int DEPTH = `RNG_FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic flush,
    stream_if.snk in_s,
    stream_if.src out_s
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
            $error("word_fifo: DEPTH must be a power of two >= 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0] cnt_ff;
    logic [WIDTH-1:0] dout_ff;
    logic dv_ff;

    wire push = in_s.valid & in_s.ready;
    wire load = (cnt_ff != '0) & (~dv_ff | out_s.ready);
    wire [AW:0] nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(load);

    assign in_s.ready = (cnt_ff != (AW+1)'(DEPTH));
    assign out_s.data = dout_ff;
    assign out_s.valid = dv_ff;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ff] <= in_s.data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst || flush) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
            dv_ff <= 1'b0;
        end else begin
            wr_ff <= wr_ff + AW'(push);
            rd_ff <= rd_ff + AW'(load);
            cnt_ff <= nxt_cnt;
            dv_ff <= load | (dv_ff & ~out_s.ready);
        end
    end

    always_ff @(posedge core_clk) begin
        if (load) begin
            dout_ff <= mem[rd_ff];
        end
    end

    a_fifo_flush_empty: assert property (@(posedge core_clk) disable iff (sys_rst)
        flush |=> (cnt_ff == '0) && !dv_ff)
        else $error("buffer not empty after flush");
endmodule

//--- design/entropy_health.sv
// raw bit health tests and vetted seed pool
`timescale 1ns/1ps
`include "rng_regs.svh"
module entropy_health #(
    parameter int SEED_W = `RNG_SEED_W,
    parameter int WIN_LEN = `RNG_WIN_LEN,
    parameter int ONES_LO = `RNG_ONES_LO,
    parameter int ONES_HI = `RNG_ONES_HI,
    parameter int RUN_LIMIT = `RNG_RUN_LIMIT
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic raw_bit,
    output logic [SEED_W-1:0] seed,
    output logic seed_stb,
    output logic pwr_ok,
    output logic defect,
    output logic total_fail
);
    localparam int WW = $clog2(WIN_LEN);
    localparam int CW = $clog2(WIN_LEN + 1);
    localparam int RW = $clog2(RUN_LIMIT + 1);

    generate
        if (WIN_LEN < SEED_W || ONES_LO > ONES_HI || RUN_LIMIT < 2) begin : g_chk
            $error("entropy_health: window shorter than seed or bad limits");
        end
    endgenerate

    logic [SEED_W-1:0] pool_ff;
    logic [WW-1:0] win_ff;
    logic [CW-1:0] ones_ff;
    logic [RW-1:0] run_ff;
    logic last_ff;
    logic run_bad_ff;
    logic [SEED_W-1:0] seed_ff;
    logic seed_stb_ff;
    logic pwr_ok_ff;
    logic defect_ff;
    logic fail_ff;

    wire win_end = (win_ff == WW'(WIN_LEN - 1));
    wire [CW-1:0] nxt_ones = ones_ff + CW'(raw_bit);
    wire same = (raw_bit == last_ff);
    wire [RW-1:0] nxt_run = same ? run_ff + RW'(1) : RW'(1);
    wire run_hit = (nxt_run >= RW'(RUN_LIMIT));
    wire in_range = (nxt_ones >= CW'(ONES_LO)) && (nxt_ones <= CW'(ONES_HI));
    wire win_good = in_range & ~run_bad_ff & ~run_hit & ~fail_ff;

    assign seed = seed_ff;
    assign seed_stb = seed_stb_ff;
    assign pwr_ok = pwr_ok_ff;
    assign defect = defect_ff;
    assign total_fail = fail_ff;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            win_ff <= '0;
            ones_ff <= '0;
            run_ff <= '0;
            last_ff <= 1'b0;
            run_bad_ff <= 1'b0;
            seed_stb_ff <= 1'b0;
            pwr_ok_ff <= 1'b0;
            defect_ff <= 1'b0;
            fail_ff <= 1'b0;
        end else begin
            win_ff <= win_end ? '0 : win_ff + WW'(1);
            ones_ff <= win_end ? '0 : nxt_ones;
            run_ff <= nxt_run;
            last_ff <= raw_bit;
            run_bad_ff <= ~win_end & (run_bad_ff | run_hit);
            fail_ff <= fail_ff | run_hit;
            seed_stb_ff <= win_end & win_good;
            if (win_end) begin
                defect_ff <= ~win_good;
                pwr_ok_ff <= pwr_ok_ff | win_good;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        pool_ff <= {pool_ff[SEED_W-2:0], raw_bit};
        if (win_end && win_good) begin
            seed_ff <= {pool_ff[SEED_W-2:0], raw_bit};
        end
    end

    a_run_sets_fail: assert property (@(posedge core_clk) disable iff (sys_rst)
        run_hit |=> fail_ff)
        else $error("stuck run did not flag total failure");
    a_pwr_after_window: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(pwr_ok_ff) |-> $past(win_end) && !$past(fail_ff))
        else $error("power-up pass without a finished window");
endmodule

//--- design/hybrid_rng.sv
// hybrid deterministic random word generator with health gating
`timescale 1ns/1ps
`include "rng_regs.svh"
module hybrid_rng #(
    parameter int WORD_W = `RNG_WORD_W,
    parameter int FIFO_DEPTH = `RNG_FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic raw_entropy,
    input wire logic reseed_req,
    input wire logic word_ready,
    output logic [WORD_W-1:0] rnd_word,
    output logic word_valid,
    output logic reseed_busy,
    output logic health_fail
);
    localparam int SW = `RNG_SEED_W;

    generate
        if (WORD_W != 32) begin : g_chk
            $error("hybrid_rng: generator lanes are 32 bits wide");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // nonlinear add-rotate-xor mixing over four 32-bit lanes
    function automatic logic [127:0] mix128(input logic [127:0] x);
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] c;
        logic [31:0] d;
        {a, b, c, d} = x;
        for (int r = 0; r < 4; r++) begin
            a = a + b;
            d = d ^ a;
            d = {d[15:0], d[31:16]};
            c = c + d;
            b = b ^ c;
            b = {b[19:0], b[31:20]};
            a = a + b;
            d = d ^ a;
            d = {d[23:0], d[31:24]};
            c = c + d;
            b = b ^ c;
            b = {b[24:0], b[31:25]};
        end
        return {a, b, c, d};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // raw entropy pin synchroniser
    logic raw_s1_ff;
    logic raw_s2_ff;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            raw_s1_ff <= 1'b0;
            raw_s2_ff <= 1'b0;
        end else begin
            raw_s1_ff <= raw_entropy;
            raw_s2_ff <= raw_s1_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // health tests and vetted seed
    logic [SW-1:0] seed;
    logic seed_stb;
    logic pwr_ok;
    logic defect;
    logic total_fail;

    entropy_health #(
        .SEED_W(SW)
    ) u_health (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .raw_bit(raw_s2_ff),
        .seed(seed),
        .seed_stb(seed_stb),
        .pwr_ok(pwr_ok),
        .defect(defect),
        .total_fail(total_fail)
    );

    ////////////////////////////////////////////////////////////////////////
    // generator state machine
    rng_pkg::gen_state_t st_ff;
    rng_pkg::gen_state_t nxt_st;
    logic [SW-1:0] gst_ff;
    logic [31:0] ctr_ff;
    logic pend_ff;
    logic busy_ff;
    logic fail_out_ff;

    stream_if #(.WIDTH(WORD_W)) gen_s ();
    stream_if #(.WIDTH(WORD_W)) buf_s ();

    wire in_gen = (st_ff == rng_pkg::ST_GEN);
    wire in_wait = (st_ff == rng_pkg::ST_WAIT);
    wire absorb = in_wait & seed_stb & ~total_fail;
    wire gen_run = in_gen & ~pend_ff & ~defect & ~total_fail & pwr_ok;
    wire produce = gen_run & gen_s.ready;
    wire [SW-1:0] out_blk = mix128(gst_ff ^ `RNG_OUT_K ^ {{3{32'h0000_0000}}, ctr_ff});
    wire [SW-1:0] upd_blk = mix128(gst_ff ^ `RNG_UPD_K) ^ gst_ff;
    wire [SW-1:0] seed_blk = mix128(gst_ff ^ seed) ^ seed;
    wire leave_gen = in_gen & (pend_ff | defect);
    wire flush = leave_gen | total_fail;
    // set wins: a request in the absorb cycle keeps the reseed pending
    wire nxt_pend = reseed_req | (pend_ff & ~absorb);
    wire gate_ok = gen_run;

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            rng_pkg::ST_WAIT: begin
                if (total_fail) begin
                    nxt_st = rng_pkg::ST_HALT;
                end else if (absorb) begin
                    nxt_st = rng_pkg::ST_GEN;
                end
            end
            rng_pkg::ST_GEN: begin
                if (total_fail) begin
                    nxt_st = rng_pkg::ST_HALT;
                end else if (pend_ff || defect) begin
                    nxt_st = rng_pkg::ST_WAIT;
                end
            end
            rng_pkg::ST_HALT: nxt_st = rng_pkg::ST_HALT;
            default: nxt_st = rng_pkg::ST_HALT;
        endcase
    end

    assign gen_s.valid = gen_run;
    assign gen_s.data = out_blk[31:0] ^ out_blk[127:96];

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_ff <= rng_pkg::ST_WAIT;
            gst_ff <= '0;
            ctr_ff <= '0;
            pend_ff <= 1'b0;
            busy_ff <= 1'b1;
            fail_out_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            pend_ff <= nxt_pend;
            busy_ff <= nxt_pend | (nxt_st != rng_pkg::ST_GEN);
            fail_out_ff <= total_fail | defect;
            if (absorb) begin
                gst_ff <= seed_blk;
            end else if (produce) begin
                gst_ff <= upd_blk;
            end
            if (produce) begin
                ctr_ff <= ctr_ff + `RNG_CTR_ONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // word buffer and gated output register
    word_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .flush(flush),
        .in_s(gen_s),
        .out_s(buf_s)
    );

    logic [WORD_W-1:0] word_ff;
    logic valid_ff;

    // output register drops its word when the gate closes
    wire take = ~valid_ff | word_ready;
    wire load_out = take & gate_ok & buf_s.valid;
    wire nxt_valid = gate_ok & (take ? buf_s.valid : 1'b1);

    assign buf_s.ready = take & gate_ok;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            valid_ff <= 1'b0;
            word_ff <= '0;
        end else begin
            valid_ff <= nxt_valid;
            if (load_out) begin
                word_ff <= buf_s.data;
            end
        end
    end

    assign rnd_word = word_ff;
    assign word_valid = valid_ff;
    assign reseed_busy = busy_ff;
    assign health_fail = fail_out_ff;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_seed_from_entropy: assert property (
        (st_ff == rng_pkg::ST_GEN && $past(st_ff) == rng_pkg::ST_WAIT) |-> $past(seed_stb))
        else $error("generator left wait without a vetted seed");

    a_reseed_blocks_out: assert property (
        reseed_req |-> ##1 reseed_busy ##1 !word_valid)
        else $error("output not blocked after reseed request");

    a_reseed_needs_seed: assert property (
        (pend_ff && !in_gen && !seed_stb) |=> pend_ff)
        else $error("reseed finished without fresh entropy");

    a_word_held_stable: assert property (
        (word_valid && !word_ready && gate_ok) |=> word_valid && $stable(rnd_word))
        else $error("unaccepted word changed while gate open");

    a_state_moves_on: assert property (
        produce |=> gst_ff != $past(gst_ff))
        else $error("generator state did not advance");

    a_counter_steps: assert property (
        produce |=> ctr_ff == $past(ctr_ff) + `RNG_CTR_ONE)
        else $error("block counter did not step by one");

    a_fail_halts_all: assert property (
        total_fail |=> st_ff == rng_pkg::ST_HALT && !word_valid && !buf_s.valid)
        else $error("total failure did not halt output");

    a_fail_stays_dark: assert property (
        (st_ff == rng_pkg::ST_HALT) |-> ##1 !word_valid [*4])
        else $error("word released after total failure");

    a_defect_withholds: assert property (
        defect |-> ##1 !word_valid)
        else $error("word released during online test defect");

    a_no_early_output: assert property (
        !pwr_ok |-> ##1 !word_valid)
        else $error("word released before power-up test passed");

    a_valid_needs_gate: assert property (
        word_valid |-> $past(gate_ok))
        else $error("valid raised while output blocked");

    // flags, flush and state bookkeeping
    a_halt_is_final: assert property (
        (st_ff == rng_pkg::ST_HALT) |=> (st_ff == rng_pkg::ST_HALT))
        else $error("generator left halt before reset");

    a_health_flag_shown: assert property (
        (total_fail || defect) |=> health_fail)
        else $error("health failure not shown on its flag");

    a_reseed_flushes_buf: assert property (
        (in_gen && pend_ff) |=> !buf_s.valid)
        else $error("buffered words kept across a reseed");

    a_absorb_ends_busy: assert property (
        (absorb && !reseed_req) |=> !reseed_busy)
        else $error("busy flag stayed up after a fresh seed");

    a_no_push_fail: assert property (
        total_fail |-> !gen_s.valid)
        else $error("generator offered a word after total failure");

    a_state_only_seeded: assert property (
        (gst_ff != $past(gst_ff)) |-> ($past(absorb) || $past(produce)))
        else $error("generator state changed without seed or update");

    a_valid_needs_pwr: assert property (
        word_valid |-> pwr_ok)
        else $error("word valid without a passed power-up test");

    a_busy_while_pending: assert property (
        pend_ff |-> reseed_busy)
        else $error("reseed pending but busy flag low");

    c_word_taken: cover property (word_valid && word_ready);
    c_reseed_done: cover property (reseed_req ##[1:600] absorb ##[1:40] word_valid);
    c_total_fail: cover property ($rose(total_fail));
    c_defect_seen: cover property ($rose(defect));
    c_word_held: cover property (word_valid && !word_ready);
endmodule

//--- tb/rng_requester.sv
// requester model: takes random words and asks for reseeds
`timescale 1ns/1ps
module rng_requester (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic slow,
    input wire logic [31:0] rnd_word,
    input wire logic word_valid,
    output logic word_ready,
    output logic reseed_req,
    output int words_taken,
    output int dup_strings,
    output int hold_err
);
    logic [127:0] group;
    logic [31:0] last_word;
    logic pending;
    int slot;
    int pace;
    logic [127:0] strings[$];

    initial begin
        word_ready = 1'b0;
        reseed_req = 1'b0;
        words_taken = 0;
        dup_strings = 0;
        hold_err = 0;
        slot = 0;
        pace = 0;
        pending = 1'b0;
    end

    ////////////////////////////////////////////////////////////
    // ready every cycle, or one cycle in three when slow
    always @(posedge core_clk) begin
        #5;
        pace = (pace + 1) % 3;
        word_ready = !slow || (pace == 0);
    end

    // four taken words make one string; strings must all differ
    always @(posedge core_clk) begin
        if (sys_rst) begin
            slot = 0;
            pending = 1'b0;
        end else begin
            if (pending && word_valid && rnd_word !== last_word) begin
                hold_err++;
            end
            pending = word_valid && !word_ready;
            last_word = rnd_word;
            if (word_valid && word_ready) begin
                words_taken++;
                group = {group[95:0], rnd_word};
                slot++;
                if (slot == 4) begin
                    foreach (strings[i]) begin
                        if (strings[i] === group) begin
                            dup_strings++;
                        end
                    end
                    strings.push_back(group);
                    slot = 0;
                end
            end
        end
    end

    // one-cycle reseed request, allowed in any state
    task automatic ask_reseed();
        @(posedge core_clk);
        #5;
        reseed_req = 1'b1;
        @(posedge core_clk);
        #5;
        reseed_req = 1'b0;
    endtask
endmodule

//--- tb/hybrid_rng_bench.sv
// self-checking bench for the health-gated random word block
`timescale 1ns/1ps
module hybrid_rng_bench;
    typedef struct {int sel; logic [31:0] exp;} note_t;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic raw_entropy = 1'b0;
    logic slow = 1'b0;
    logic [31:0] rnd_word;
    logic word_valid;
    logic word_ready;
    logic reseed_req;
    logic reseed_busy;
    logic health_fail;
    int words_taken;
    int dup_strings;
    int hold_err;
    int n_mismatch = 0;
    int samples_checked = 0;
    int mode = 0;
    int cyc = 0;
    logic [31:0] ent_state = 32'h6668_fc39;
    note_t notes[$];
    note_t cur;
    string names[7] = '{"word_valid", "reseed_busy", "health_fail", "dup_strings",
        "hold_err", "rnd_word", "words_flowing"};

    always #25 core_clk = ~core_clk;

    hybrid_rng i_hybrid_rng (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .raw_entropy(raw_entropy),
        .reseed_req(reseed_req),
        .word_ready(word_ready),
        .rnd_word(rnd_word),
        .word_valid(word_valid),
        .reseed_busy(reseed_busy),
        .health_fail(health_fail)
    );

    rng_requester i_rng_requester (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .slow(slow),
        .rnd_word(rnd_word),
        .word_valid(word_valid),
        .word_ready(word_ready),
        .reseed_req(reseed_req),
        .words_taken(words_taken),
        .dup_strings(dup_strings),
        .hold_err(hold_err)
    );

    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // entropy pin: random, stuck high, stuck low, or starved of ones
    always @(posedge core_clk) begin
        #5;
        cyc++;
        ent_state = lfsr_next(ent_state);
        case (mode)
            0: raw_entropy = ent_state[0];
            1: raw_entropy = 1'b1;
            2: raw_entropy = 1'b0;
            default: raw_entropy = (cyc % 6 == 0);
        endcase
    end

    function automatic logic [31:0] observe(int sel);
        case (sel)
            0: return 32'(word_valid);
            1: return 32'(reseed_busy);
            2: return 32'(health_fail);
            3: return 32'(dup_strings);
            4: return 32'(hold_err);
            5: return rnd_word;
            default: return 32'(words_taken > 40);
        endcase
    endfunction

    task automatic note(int sel, logic [31:0] exp);
        notes.push_back('{sel, exp});
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge core_clk);
        #5;
    endtask

    task automatic stay(int sel, logic [31:0] val, int n);
        repeat (n) begin
            tick(1);
            note(sel, val);
        end
    endtask

    task automatic wait_for(int sel, logic [31:0] val, int limit);
        int k = 0;
        while (observe(sel) !== val && k < limit) begin
            tick(1);
            k++;
        end
        note(sel, val);
    endtask

    task automatic do_reset(int m);
        sys_rst = 1'b1;
        mode <= m;
        tick(5);
        sys_rst = 1'b0;
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // every queued note is compared, oldest first, once the outputs have settled
    always @(negedge core_clk) begin
        while (notes.size() > 0) begin
            cur = notes.pop_front();
            samples_checked++;
            if (observe(cur.sel) !== cur.exp) begin
                n_mismatch++;
                $display("wrong value %s expected %0h seen %0h", names[cur.sel], cur.exp,
                    observe(cur.sel));
            end
        end
    end

    initial begin
        #2000000;
        n_mismatch++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////
    initial begin
        do_reset(0);
        tick(1);
        note(1, 1'h1);
        note(0, 1'h0);
        note(2, 1'h0);
        note(5, 32'h0000_0000);
        stay(0, 1'h0, 120);
        wait_for(0, 1'h1, 800);
        note(2, 1'h0);
        tick(300);
        slow <= 1'b1;
        tick(300);
        slow <= 1'b0;
        i_rng_requester.ask_reseed();
        note(1, 1'h1);
        tick(1);
        note(0, 1'h0);
        i_rng_requester.ask_reseed();
        note(1, 1'h1);
        wait_for(1, 1'h0, 800);
        wait_for(0, 1'h1, 20);
        tick(100);
        mode <= 3;
        wait_for(2, 1'h1, 800);
        tick(2);
        note(0, 1'h0);
        mode <= 0;
        wait_for(2, 1'h0, 800);
        wait_for(0, 1'h1, 800);
        tick(50);
        mode <= 1;
        wait_for(2, 1'h1, 60);
        tick(2);
        mode <= 0;
        stay(0, 1'h0, 400);
        note(2, 1'h1);
        do_reset(2);
        stay(0, 1'h0, 300);
        note(2, 1'h1);
        note(3, 32'h0000_0000);
        note(4, 32'h0000_0000);
        note(6, 1'h1);
        tick(2);
        complete_run();
    end
endmodule
